// ===== rtl/cmd_sync.sv
`timescale 1ns/100ps
`default_nettype none
module cmd_sync #(parameter int W = 1)
(
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;
  sync_s r;
  sync_s next_r;
  always_comb
  begin
    next_r    = r;
    next_r.s1 = d_in;
    next_r.s2 = r.s1;
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      r <= '0;
    else
      r <= next_r;
  end
  assign q_out = r.s2;
endmodule
`default_nettype wire

// ===== rtl/mode_regs.sv
// Overview of operation
// RULE1: Output-disable bit set floats all data and strobe outputs.
// RULE2: Controller keeps output-disable clear except for special measurements.
// RULE3: Mode set with bank 2 code loads mode_register_two from address.
// RULE4: Controller writes reserved mode_register_two bits as zero.
// RULE5: Write CAS delay taken from address bits 5:3, whole cycles.
// RULE6: Write latency equals additive latency plus write CAS delay.
// RULE7: Extended-temperature self-refresh needs auto or range option set.
// RULE8: Dynamic write termination taken from address bits 10:9.
// RULE9: Write termination applies during writes even with nominal off.
// RULE10: No dynamic termination while write leveling is active.
// RULE11: Mode set with bank 3 code loads mode_register_three.
// RULE12: Pattern enable clear ignores location and uses the array.
// RULE13: Controller idles all banks before enabling pattern readout.
// RULE14: Pattern enable redirects reads to the selected store location.
// RULE15: Only reads allowed until pattern readout is disabled.
// RULE16: Reset still works while pattern readout is enabled.
// RULE17: Read with autoclose acts as plain read in pattern mode.
// RULE18: Bit 0 of each lane carries pattern; bits 7:1 copy it.
// RULE19: Controller drives column bits 1:0 as zero; others ignored.
// RULE20: Eight-beat order 0..7; chopped reads pick nibble by A2.
// RULE21: Burst chop from mode register or on the fly honoured.
// RULE22: Pattern reads use the normal read latency.
// RULE23: Controller waits for DLL lock before pattern reads.
// RULE24: Beat 0 is the LSB, beat 7 the MSB of the location.
// RULE25: Location 00 returns 0,1,0,1,0,1,0,1; others reserved.
// RULE26: Mode registers hold until next targeting mode set or reset.
`timescale 1ns/100ps
`default_nettype none
`include "mode_regs_cfg.svh"
module mode_regs
(
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  input  wire logic                         ce_in,
  input  wire logic                         link_clk_in,
  input  wire logic                         cs_n_in,
  input  wire logic                         ras_n_in,
  input  wire logic                         cas_n_in,
  input  wire logic                         we_n_in,
  input  wire logic [`BA_W-1:0]             ba_in,
  input  wire logic [`ADDR_W-1:0]           addr_in,
  input  wire logic                         chop_mode_in,
  input  wire logic                         chop_otf_en_in,
  input  wire logic [4:0]                   read_latency_in,
  input  wire logic                         write_in,
  input  wire logic                         array_valid_in,
  input  wire mode_regs_pkg::lane_pair_t    array_data_in,
  output var  mode_regs_pkg::lane_pair_t    dq_out,
  output logic                              dq_oe_out,
  output logic                              dqs_oe_out,
  output var  logic [`CWD_W-1:0]            write_cas_delay_out,
  output var  logic                         auto_selfrefresh_temp_out,
  output var  logic                         selfrefresh_temp_range_out,
  output logic [`RTTWR_W-1:0]               write_termination_out,
  output var  logic                         pattern_mode_out,
  output logic                              array_read_out,
  output logic                              autoclose_out
);
  import mode_regs_pkg::*;

  typedef struct packed
  {
    logic [`ADDR_W-1:0] cmd_addr;
    logic [`BA_W-1:0]   cmd_ba;
    logic [3:0]         cmd_pins;
    logic               cmd_tog;
  } link_s;

  typedef struct packed
  {
    logic [`ADDR_W-1:0] mr1;
    logic [`ADDR_W-1:0] mr2;
    logic [`ADDR_W-1:0] mr3;
    logic               tog_dly;
    logic               tog_seen;
    read_state_e        state;
    logic [4:0]         wait_cnt;
    logic [3:0]         beat;
    logic [3:0]         last_beat;
    logic [7:0]         shifter;
    lane_pair_t         dq;
    logic               dq_drive;
    logic               arr_rd;
    logic               aclose;
  } core_s;

  link_s l;
  link_s next_l;
  core_s r;
  core_s next_r;

  logic [`ADDR_W-1:0] s_addr;
  logic [`BA_W-1:0]   s_ba;
  logic [3:0]         s_pins;
  logic               s_tog;
  logic [7:0]         pattern;

  // Link side captures a command on each rising edge of link_clk_in with cs_n_in low and flags it with a toggle
  always_comb
  begin
    next_l = l;
    if (!cs_n_in)
    begin
      next_l.cmd_addr = addr_in;
      next_l.cmd_ba   = ba_in;
      next_l.cmd_pins = {ras_n_in, cas_n_in, we_n_in, 1'b0};
      next_l.cmd_tog  = ~l.cmd_tog;
    end
  end

  always_ff @(posedge link_clk_in or posedge rst_in)
  begin
    if (rst_in)
      l <= '0;
    else
      l <= next_l;
  end

  // Command words are held stable for a full link period past the toggle
  cmd_sync #(.W(`ADDR_W + `BA_W + 4)) u_data_sync
  (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   ({l.cmd_addr, l.cmd_ba, l.cmd_pins}),
    .q_out  ({s_addr, s_ba, s_pins})
  );

  cmd_sync #(.W(1)) u_tog_sync
  (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (l.cmd_tog),
    .q_out  (s_tog)
  );

  pattern_store u_store
  (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .loc_in      (r.mr3[`LOC_W-1:0]),
    .pattern_out (pattern)
  );

  function automatic logic cmd_is(input logic [3:0] pins, input logic [3:0] code);
    cmd_is = (pins == code);
  endfunction

  logic new_cmd;
  logic is_mrs;
  logic is_read;
  logic pat_en;
  logic chopped;

  always_comb
  begin
    // Decode one cycle after the toggle lands, so a slow data bit has settled
    new_cmd = (r.tog_dly != r.tog_seen);
    is_mrs  = new_cmd && cmd_is(s_pins, `CMD_MRS);
    is_read = new_cmd && cmd_is(s_pins, `CMD_READ);
    pat_en  = r.mr3[`CPS_EN_BIT];
    chopped = (chop_otf_en_in ? !s_addr[`CHOP_BIT] : chop_mode_in); // [RULE21]
  end

  always_comb
  begin
    next_r          = r;
    next_r.tog_dly  = s_tog;
    next_r.tog_seen = r.tog_dly;
    next_r.arr_rd   = 1'b0;
    next_r.aclose   = 1'b0;
    if (is_mrs)
    begin
      case (s_ba)
        `BA_MR1: next_r.mr1 = s_addr;
        `BA_MR2: next_r.mr2 = s_addr; // [RULE3] [RULE26]
        `BA_MR3: next_r.mr3 = s_addr; // [RULE11] [RULE26]
        default: next_r.mr1 = r.mr1;
      endcase
    end
    case (r.state)
      st_idle:
      begin
        next_r.dq_drive = 1'b0;
        if (is_read && pat_en)
        begin
          // Autoclose bit deliberately unused here [RULE14] [RULE17] [RULE19]
          next_r.state     = st_wait;
          next_r.wait_cnt  = read_latency_in; // [RULE22]
          next_r.beat      = (chopped && s_addr[`NIBBLE_BIT]) ? `BEATS_BC4 : 4'h0; // [RULE20]
          next_r.last_beat = (chopped && !s_addr[`NIBBLE_BIT]) ? `BEATS_BC4 : `BEATS_BL8;
          next_r.shifter   = pattern;
        end
        else if (is_read)
        begin
          next_r.arr_rd = 1'b1; // [RULE12]
          next_r.aclose = s_addr[`AUTOCLOSE_BIT];
        end
      end
      st_wait:
      begin
        if (r.wait_cnt == 5'h0)
          next_r.state = st_send;
        else
          next_r.wait_cnt = r.wait_cnt - 5'h1;
      end
      st_send:
      begin
        next_r.dq_drive = 1'b1;
        next_r.dq = {{8{r.shifter[r.beat[2:0]]}}, {8{r.shifter[r.beat[2:0]]}}}; // [RULE18] [RULE24]
        next_r.beat = r.beat + 4'h1;
        if (r.beat + 4'h1 == r.last_beat)
          next_r.state = st_idle;
      end
      default: next_r.state = st_idle;
    endcase
    if (!pat_en && r.state == st_idle && array_valid_in)
    begin
      next_r.dq       = array_data_in;
      next_r.dq_drive = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      r <= '0; // [RULE16]
    else if (ce_in)
      r <= next_r;
  end

  always_comb
  begin
    dq_oe_out     = r.dq_drive && !r.mr1[`QOFF_BIT]; // [RULE1]
    dqs_oe_out    = r.dq_drive && !r.mr1[`QOFF_BIT]; // [RULE1]
    // Dynamic termination only during writes and never while leveling
    write_termination_out = (write_in && !r.mr1[`WLEVEL_BIT])
                            ? r.mr2[`RTTWR_LO +: `RTTWR_W] : `RTT_OFF; // [RULE8] [RULE9] [RULE10]
    array_read_out = r.arr_rd;
    autoclose_out  = r.aclose;
  end

  assign dq_out                     = r.dq;
  assign write_cas_delay_out        = r.mr2[`CWD_LO +: `CWD_W]; // [RULE5] [RULE6]
  assign auto_selfrefresh_temp_out  = r.mr2[`ASR_BIT];
  assign selfrefresh_temp_range_out = r.mr2[`SRT_BIT];
  assign pattern_mode_out           = r.mr3[`CPS_EN_BIT];

  a_qoff_floats: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE1]
    r.mr1[`QOFF_BIT] |-> !dq_oe_out && !dqs_oe_out) else $error("outputs driven while disabled");
  a_mr2_load: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE3]
    ce_in && is_mrs && s_ba == `BA_MR2 |=> r.mr2 == $past(s_addr)) else $error("mr2 not loaded");
  a_mr3_load: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE11]
    ce_in && is_mrs && s_ba == `BA_MR3 |=> r.mr3 == $past(s_addr)) else $error("mr3 not loaded");
  a_mr_hold: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE26]
    !is_mrs |=> $stable(r.mr2) && $stable(r.mr3)) else $error("mode register changed");
  a_level_no_rtt: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE10]
    r.mr1[`WLEVEL_BIT] |-> write_termination_out == `RTT_OFF) else $error("rtt during leveling");
  a_array_redirect: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE14]
    ce_in && is_read && pat_en && r.state == st_idle |=> !array_read_out)
    else $error("array read in pattern mode");
  a_normal_read: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE12]
    ce_in && is_read && !pat_en && r.state == st_idle |=> array_read_out) else $error("array read lost");
  a_lane_copy: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE18]
    r.state == st_send |=> dq_out[7:0] == {8{dq_out[0]}} && dq_out[15:8] == dq_out[7:0])
    else $error("lane mismatch");
  a_cwd_field: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE5]
    ce_in && is_mrs && s_ba == `BA_MR2 |=> write_cas_delay_out == $past(s_addr[`CWD_LO +: `CWD_W]))
    else $error("cwd wrong");
  c_pattern_read: cover property (@(posedge clk_in) r.state == st_send);
  c_mr3_enable: cover property (@(posedge clk_in) is_mrs && s_ba == `BA_MR3 && s_addr[`CPS_EN_BIT]);
  c_array_read: cover property (@(posedge clk_in) array_read_out);
endmodule
`default_nettype wire

// ===== rtl/pattern_store.sv
`timescale 1ns/100ps
`default_nettype none
`include "mode_regs_cfg.svh"
module pattern_store
(
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic                ce_in,
  input  wire logic [`LOC_W-1:0]   loc_in,
  output var  logic [`LANE_W-1:0]  pattern_out
);
  typedef struct packed
  {
    logic [`LANE_W-1:0] data;
  } store_s;
  store_s r;
  store_s next_r;
  // Only location zero is defined; reserved codes read as zero
  always_comb
  begin
    next_r = r;
    next_r.data = (loc_in == `LOC_ALT) ? `ALT_PATTERN : '0; // [RULE25]
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      r <= '0;
    else if (ce_in)
      r <= next_r;
  end
  assign pattern_out = r.data;
endmodule
`default_nettype wire

// ===== shared/mode_regs_cfg.svh
`ifndef MODE_REGS_CFG_SVH
`define MODE_REGS_CFG_SVH
`define ADDR_W          16
`define BA_W            3
`define BA_MR1          3'h1
`define BA_MR2          3'h2
`define BA_MR3          3'h3
`define QOFF_BIT        12
`define WLEVEL_BIT      7
`define CWD_LO          3
`define CWD_W           3
`define ASR_BIT         6
`define SRT_BIT         7
`define RTTWR_LO        9
`define RTTWR_W         2
`define CPS_EN_BIT      2
`define LOC_W           2
`define LOC_ALT         2'h0
`define CHOP_BIT        12
`define NIBBLE_BIT      2
`define ALT_PATTERN     8'haa
`define RL_MAX          5'h1f
`define BEATS_BL8       4'h8
`define BEATS_BC4       4'h4
`define LANE_W          8
`define RTT_OFF         2'h0
`define AUTOCLOSE_BIT   10
`define CMD_MRS         4'h0
`define CMD_READ        4'ha
`endif

// ===== shared/mode_regs_pkg.sv
package mode_regs_pkg;
  typedef enum logic [1:0]
  {
    st_idle = 2'h0,
    st_wait = 2'h1,
    st_send = 2'h3
  } read_state_e;
  typedef logic [15:0] lane_pair_t;
endpackage

// ===== test/ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "mode_regs_cfg.svh"
module ctrl_model
(
  input  wire logic               link_clk_in,
  output var  logic               cs_n_out,
  output var  logic               ras_n_out,
  output var  logic               cas_n_out,
  output var  logic               we_n_out,
  output var  logic [`BA_W-1:0]   ba_out,
  output var  logic [`ADDR_W-1:0] addr_out
);
  initial
  begin
    {cs_n_out, ras_n_out, cas_n_out, we_n_out, ba_out, addr_out} = {4'hf, 3'h0, 16'h0000};
  end
  // Banks idle, lock done, reads only in pattern mode
  task automatic issue(input logic [2:0] cmd, input logic [2:0] ba, input logic [15:0] a);
    @(posedge link_clk_in);
    #1;
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = {1'b0, cmd};
    ba_out = ba;
    addr_out = (ba == `BA_MR2) ? (a & 16'h06d8) : a;
    @(posedge link_clk_in);
    #1;
    cs_n_out = 1'b1;
    // Deselected lines must not look like the last command
    {ras_n_out, cas_n_out, we_n_out, ba_out, addr_out} = ~{ras_n_out, cas_n_out, we_n_out, ba_out, addr_out};
  endtask
endmodule
`default_nettype wire

// ===== test/mode_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "mode_regs_cfg.svh"
module mode_regs_bench;
  import mode_regs_pkg::*;
  logic       clk_in, rst_in, link_clk, chop_otf, wr, dq_oe, dqs_oe, auto_selfrefresh_temp, selfrefresh_temp_range, pmode, arr_rd, aclose;
  logic       cs_n, ras_n, cas_n, we_n, seen, chop_fixed, arr_valid;
  logic [2:0] ba, cwd;
  logic [15:0] addr, arr_data;
  logic [1:0] rtt;
  lane_pair_t dq;
  int         bad_count = 0;
  int         samples_checked = 0;
  localparam logic [2:0] MRS = 3'h0;
  localparam logic [2:0] RD = 3'h5;
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial
  begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end
  ctrl_model ctrl_model_i (.link_clk_in(link_clk), .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n),
    .we_n_out(we_n), .ba_out(ba), .addr_out(addr));
  mode_regs mode_regs_i (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .link_clk_in(link_clk),
    .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .ba_in(ba), .addr_in(addr),
    .chop_mode_in(chop_fixed), .chop_otf_en_in(chop_otf), .read_latency_in(5'h03), .write_in(wr),
    .array_valid_in(arr_valid), .array_data_in(arr_data), .dq_out(dq), .dq_oe_out(dq_oe), .dqs_oe_out(dqs_oe),
    .write_cas_delay_out(cwd), .auto_selfrefresh_temp_out(auto_selfrefresh_temp), .selfrefresh_temp_range_out(selfrefresh_temp_range),
    .write_termination_out(rtt), .pattern_mode_out(pmode), .array_read_out(arr_rd), .autoclose_out(aclose));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    check_word(what, {15'h0, exp}, {15'h0, got});
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic mrs(input logic [2:0] ba_v, input logic [15:0] a);
    ctrl_model_i.issue(MRS, ba_v, a);
    tick(30);
  endtask
  // Read and watch bursts; no array access may show in pattern mode
  task automatic burst(input logic [15:0] a, input int beats, input int first, input logic [7:0] pat);
    int w;
    ctrl_model_i.issue(RD, 3'h7, a);
    seen = 1'b0;
    for (w = 0; w < 40 && dq_oe !== 1'b1; w++)
    begin
      seen = seen | (arr_rd === 1'b1) | (aclose === 1'b1);
      tick(1);
    end
    check_bit("array access", 1'b0, seen);
    check_bit("oe rise", 1'b1, dq_oe);
    for (w = 0; w < beats; w++)
    begin
      check_word("beat", {16{pat[first + w]}}, dq);
      check_bit("strobe oe", 1'b1, dqs_oe);
      tick(1);
    end
    check_bit("oe fall", 1'b0, dq_oe);
    tick(20);
  endtask
  task automatic mr2_test;
    mrs(`BA_MR2, 16'h04d8);
    check_word("cwd", 16'h0003, {13'h0, cwd});
    check_bit("asr", 1'b1, auto_selfrefresh_temp);
    check_bit("srt", 1'b1, selfrefresh_temp_range);
    check_word("rtt idle", 16'h0000, {14'h0, rtt});
    wr = 1'b1;
    tick(2);
    check_word("rtt write", 16'h0002, {14'h0, rtt});
    mrs(`BA_MR1, 16'h0080);
    check_word("rtt leveling", 16'h0000, {14'h0, rtt});
    check_word("cwd kept", 16'h0003, {13'h0, cwd});
    wr = 1'b0;
    mrs(`BA_MR1, 16'h0000);
  endtask
  task automatic pattern_test;
    int w;
    mrs(`BA_MR3, 16'h0004);
    check_bit("pattern mode", 1'b1, pmode);
    burst(16'h1400, 8, 0, `ALT_PATTERN);
    chop_otf = 1'b1;
    burst(16'h0004, 4, 4, `ALT_PATTERN);
    burst(16'h0000, 4, 0, `ALT_PATTERN);
    chop_otf = 1'b0;
    chop_fixed = 1'b1;
    burst(16'h1004, 4, 4, `ALT_PATTERN);
    chop_fixed = 1'b0;
    // Leave pattern mode before picking another location
    mrs(`BA_MR3, 16'h0000);
    mrs(`BA_MR3, 16'h0005);
    burst(16'h1000, 8, 0, 8'h00);
    mrs(`BA_MR3, 16'h0003);
    check_bit("pattern off", 1'b0, pmode);
    ctrl_model_i.issue(RD, 3'h0, 16'h0400);
    seen = 1'b0;
    for (w = 0; w < 40 && seen !== 1'b1; w++)
    begin
      tick(1);
      seen = (arr_rd === 1'b1);
    end
    check_bit("array read", 1'b1, seen);
    check_bit("autoclose", 1'b1, aclose);
    arr_valid = 1'b1;
    arr_data = 16'h5a3c;
    tick(1);
    check_word("array data", 16'h5a3c, dq);
    check_bit("array oe", 1'b1, dq_oe);
    arr_valid = 1'b0;
    tick(1);
    check_bit("array oe off", 1'b0, dq_oe);
    tick(20);
  endtask
  task automatic disable_test;
    int w;
    // Output disable goes in first: no mode set is allowed once pattern mode is on
    mrs(`BA_MR1, 16'h1000);
    mrs(`BA_MR3, 16'h0004);
    check_bit("pattern armed", 1'b1, pmode);
    ctrl_model_i.issue(RD, 3'h0, 16'h1000);
    seen = 1'b0;
    for (w = 0; w < 40; w++)
    begin
      tick(1);
      seen = seen | (dq_oe !== 1'b0) | (dqs_oe !== 1'b0);
    end
    check_bit("outputs floated", 1'b0, seen);
  endtask
  task automatic reset_test;
    rst_in = 1'b1;
    tick(4);
    rst_in = 1'b0;
    tick(4);
    check_bit("reset pattern", 1'b0, pmode);
    check_word("reset cwd", 16'h0000, {13'h0, cwd});
  endtask
  initial
  begin
    rst_in = 1'b1;
    chop_otf = 1'b0;
    chop_fixed = 1'b0;
    arr_valid = 1'b0;
    arr_data = 16'h0000;
    wr = 1'b0;
    tick(4);
    rst_in = 1'b0;
    tick(10);
    mr2_test();
    pattern_test();
    disable_test();
    reset_test();
    tally_and_finish();
  end
  // Whole run needs about 7.1 us
  initial
  begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
